// [src/ppp_pkg.sv]
// Package with codes, widths and timing counts of the parallel programming port.
package ppp_pkg;
  localparam int CLK_PERIOD_NS = 25;
  localparam int PULSE_MIN_NS = 250;
  localparam int PULSE_MIN_CYC = (PULSE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int ENTRY_HOLD_US = 10;
  localparam int ENTRY_HOLD_CYC = (ENTRY_HOLD_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CMD_WAIT_US = 300;
  localparam int CMD_WAIT_CYC = (CMD_WAIT_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int ERASE_CYC_DEF = 64;
  localparam int WRITE_CYC_DEF = 32;
  localparam int PAGE_WORDS = 32;
  localparam int PAGE_IDX_W = 5;

  localparam logic [1:0] ACT_ADDR = 2'h0;
  localparam logic [1:0] ACT_DATA = 2'h1;
  localparam logic [1:0] ACT_CMD = 2'h2;
  localparam logic [1:0] ACT_IDLE = 2'h3;

  localparam logic [7:0] CMD_NOP = 8'h00;
  localparam logic [7:0] CMD_CHIP_ERASE = 8'h80;
  localparam logic [7:0] CMD_WR_FUSE = 8'h40;
  localparam logic [7:0] CMD_WR_LOCK = 8'h20;
  localparam logic [7:0] CMD_WR_FLASH = 8'h10;
  localparam logic [7:0] CMD_WR_EEPROM = 8'h11;
  localparam logic [7:0] CMD_RD_SIG = 8'h08;
  localparam logic [7:0] CMD_RD_FUSE_LOCK = 8'h04;
  localparam logic [7:0] CMD_RD_FLASH = 8'h02;
  localparam logic [7:0] CMD_RD_EEPROM = 8'h03;

  localparam logic [7:0] BYTE_ERASED = 8'hFF;
  localparam logic [7:0] FUSE_LO_RESET = 8'h62;
  localparam logic [7:0] FUSE_HI_RESET = 8'hDF;
  localparam logic [7:0] FUSE_EXT_RESET = 8'hF9;
  localparam int PRESERVE_FUSE_BIT = 3;

  // Arbitrary neutral identity bytes.
  localparam logic [7:0] SIG_BYTE0 = 8'h5A;
  localparam logic [7:0] SIG_BYTE1 = 8'h01;
  localparam logic [7:0] SIG_BYTE2 = 8'h02;
  localparam logic [7:0] CAL_BYTE = 8'h80;

  // One-cycle rising-edge detect from a held previous sample.
  function automatic logic ppp_rise(input logic now_v, input logic prev_v);
    return now_v & ~prev_v;
  endfunction : ppp_rise
endpackage : ppp_pkg

// [src/ppp_if.sv]
// Pin bundle between parallel programmer and device port.
interface ppp_if;
  logic load_strobe;
  logic action_select_bit0;
  logic action_select_bit1;
  logic byte_select_lo_hi;
  logic byte_select_extended;
  logic page_buffer_latch;
  logic write_n;
  logic output_enable_n;
  logic ready_busy_out;
  logic [7:0] data_host;
  logic data_host_oe;
  logic [7:0] data_dev;
  logic data_dev_oe;
  logic [7:0] data_bus;

  assign data_bus = data_dev_oe ? data_dev : (data_host_oe ? data_host : 8'hFF);

  modport device (
    input load_strobe, action_select_bit0, action_select_bit1, byte_select_lo_hi,
    input byte_select_extended, page_buffer_latch, write_n, output_enable_n, data_bus,
    output ready_busy_out, data_dev, data_dev_oe
  );
  modport host (
    output load_strobe, action_select_bit0, action_select_bit1, byte_select_lo_hi,
    output byte_select_extended, page_buffer_latch, write_n, output_enable_n,
    output data_host, data_host_oe,
    input ready_busy_out, data_bus
  );
endinterface : ppp_if

// [src/ppp_pulse_gen.sv]
// Timed pulse generator used by the programmer for each strobe.
module ppp_pulse_gen (
  // Clock and reset
  input wire logic core_clk_in,
  input wire logic srst_in,
  // Control
  input wire logic start_in,
  input wire logic [15:0] width_in,
  // Status
  output logic active_out,
  output logic done_out
);
  import ppp_pkg::*;
  logic [15:0] cnt_reg, cnt_next;
  logic active_reg, active_next;
  logic done_reg, done_next;

  always_comb begin
    cnt_next = cnt_reg;
    active_next = active_reg;
    done_next = 1'b0;
    if (active_reg) begin
      if (cnt_reg <= 16'h0001) begin
        active_next = 1'b0;
        done_next = 1'b1;
      end else begin
        cnt_next = cnt_reg - 16'h0001;
      end
    end else if (start_in) begin
      active_next = 1'b1;
      cnt_next = width_in;
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (srst_in) begin
      cnt_reg <= 16'h0000;
      active_reg <= 1'b0;
      done_reg <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      active_reg <= active_next;
      done_reg <= done_next;
    end
  end

  assign active_out = active_reg;
  assign done_out = done_reg;
endmodule : ppp_pulse_gen

// [src/ppp_device.sv]
// Device end of the parallel programming port: entry latch, loaders, command execution.
module ppp_device #(
  parameter int ERASE_CYC = ppp_pkg::ERASE_CYC_DEF,
  parameter int WRITE_CYC = ppp_pkg::WRITE_CYC_DEF
) (
  // Clock and reset
  input wire logic core_clk_in,
  input wire logic srst_in,
  // Programming pins
  ppp_if.device pins,
  // User side
  input wire logic hv_enter_in,
  output logic prog_mode_out,
  output logic [7:0] fuse_low_out,
  output logic [7:0] fuse_high_out,
  output logic [7:0] lock_out
);
  import ppp_pkg::*;

  typedef enum logic [1:0] {PPP_OFF, PPP_ENTRY, PPP_READY, PPP_BUSY} ppp_state_e;
  ppp_state_e state_reg, state_next;
  logic [15:0] cnt_reg, cnt_next;
  logic ls_prev_reg, wr_prev_reg, pl_prev_reg;
  logic [7:0] cmd_reg, cmd_next;
  logic [7:0] addr_lo_reg, addr_lo_next, addr_hi_reg, addr_hi_next;
  logic [7:0] dat_lo_reg, dat_lo_next, dat_hi_reg, dat_hi_next;
  logic [7:0] flash_lo [PAGE_WORDS];
  logic [7:0] flash_hi [PAGE_WORDS];
  logic [7:0] ee [PAGE_WORDS];
  logic [7:0] pbuf_lo [PAGE_WORDS];
  logic [7:0] pbuf_hi [PAGE_WORDS];
  logic [7:0] fuse_lo_reg, fuse_lo_next, fuse_hi_reg, fuse_hi_next, fuse_ext_reg, fuse_ext_next;
  logic [7:0] lock_reg, lock_next;
  logic [7:0] rd_reg, rd_next;
  logic oe_reg, oe_next;
  logic rb_reg, rb_next, prog_reg, prog_next;
  logic pend_lock_reg, pend_lock_next;
  logic do_pload, do_flash_wr, do_ee_wr, do_erase;
  logic [1:0] act;
  logic [PAGE_IDX_W-1:0] widx;

  assign act = {pins.action_select_bit1, pins.action_select_bit0};
  assign widx = addr_lo_reg[PAGE_IDX_W-1:0];

  always_comb begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    cmd_next = cmd_reg;
    addr_lo_next = addr_lo_reg;
    addr_hi_next = addr_hi_reg;
    dat_lo_next = dat_lo_reg;
    dat_hi_next = dat_hi_reg;
    fuse_lo_next = fuse_lo_reg;
    fuse_hi_next = fuse_hi_reg;
    fuse_ext_next = fuse_ext_reg;
    lock_next = lock_reg;
    pend_lock_next = 1'b0;
    rb_next = rb_reg;
    do_pload = 1'b0;
    do_flash_wr = 1'b0;
    do_ee_wr = 1'b0;
    do_erase = 1'b0;
    unique case (state_reg)
      PPP_OFF: begin
        // Entry pattern is checked while high voltage rises.
        if (hv_enter_in && !pins.page_buffer_latch && act == ACT_ADDR && !pins.byte_select_lo_hi) begin
          state_next = PPP_ENTRY;
          cnt_next = 16'h0000;
        end
      end
      PPP_ENTRY: begin
        if (!hv_enter_in || pins.page_buffer_latch || act != ACT_ADDR || pins.byte_select_lo_hi) begin
          state_next = PPP_OFF;
        end else if (cnt_reg == 16'(ENTRY_HOLD_CYC - 1)) begin
          state_next = PPP_READY;
          rb_next = 1'b1;
        end else begin
          cnt_next = cnt_reg + 16'h0001;
        end
      end
      PPP_READY: begin
        if (ppp_rise(pins.load_strobe, ls_prev_reg)) begin
          unique case (act)
            ACT_ADDR: if (pins.byte_select_lo_hi) addr_hi_next = pins.data_bus;
                      else addr_lo_next = pins.data_bus;
            ACT_DATA: if (pins.byte_select_lo_hi) dat_hi_next = pins.data_bus;
                      else dat_lo_next = pins.data_bus;
            ACT_CMD: cmd_next = pins.data_bus;
            ACT_IDLE: ;
          endcase
        end
        if (ppp_rise(pins.page_buffer_latch, pl_prev_reg)) do_pload = 1'b1;
        // A falling write strobe runs the held command; command and address stay.
        if (ppp_rise(wr_prev_reg, pins.write_n)) begin
          unique case (cmd_reg)
            CMD_CHIP_ERASE: begin
              state_next = PPP_BUSY;
              rb_next = 1'b0;
              cnt_next = 16'(ERASE_CYC);
              do_erase = 1'b1;
            end
            CMD_WR_FUSE, CMD_WR_LOCK, CMD_WR_FLASH, CMD_WR_EEPROM: begin
              state_next = PPP_BUSY;
              rb_next = 1'b0;
              cnt_next = 16'(WRITE_CYC);
              if (cmd_reg == CMD_WR_FLASH) do_flash_wr = 1'b1;
              if (cmd_reg == CMD_WR_EEPROM) do_ee_wr = 1'b1;
              if (cmd_reg == CMD_WR_LOCK) lock_next = lock_reg & dat_lo_reg;
              if (cmd_reg == CMD_WR_FUSE) begin
                if (pins.byte_select_extended) fuse_ext_next = dat_lo_reg;
                else if (pins.byte_select_lo_hi) fuse_hi_next = dat_lo_reg;
                else fuse_lo_next = dat_lo_reg;
              end
            end
            default: ;
          endcase
        end
      end
      PPP_BUSY: begin
        // Write strobes are ignored here.
        pend_lock_next = pend_lock_reg;
        if (cnt_reg <= 16'h0001) begin
          state_next = PPP_READY;
          rb_next = 1'b1;
          // Lock bits clear only when the chip erase busy period ends, after the flash was erased.
          if (pend_lock_reg) lock_next = BYTE_ERASED;
          pend_lock_next = 1'b0;
        end else begin
          cnt_next = cnt_reg - 16'h0001;
        end
      end
    endcase
    if (do_erase) pend_lock_next = 1'b1;
    prog_next = (state_next == PPP_READY) || (state_next == PPP_BUSY);
  end

  // Read mux: low/high and extended selects pick the byte.
  always_comb begin
    rd_next = BYTE_ERASED;
    oe_next = (state_reg == PPP_READY) && !pins.output_enable_n;
    unique case (cmd_reg)
      CMD_RD_FLASH: rd_next = pins.byte_select_lo_hi ? flash_hi[widx] : flash_lo[widx];
      CMD_RD_EEPROM: rd_next = ee[widx];
      CMD_RD_SIG: begin
        if (pins.byte_select_lo_hi) rd_next = CAL_BYTE;
        else if (addr_lo_reg == 8'h00) rd_next = SIG_BYTE0;
        else if (addr_lo_reg == 8'h01) rd_next = SIG_BYTE1;
        else rd_next = SIG_BYTE2;
      end
      CMD_RD_FUSE_LOCK: begin
        unique case ({pins.byte_select_extended, pins.byte_select_lo_hi})
          2'h0: rd_next = fuse_lo_reg;
          2'h3: rd_next = fuse_hi_reg;
          2'h2: rd_next = fuse_ext_reg;
          2'h1: rd_next = lock_reg;
        endcase
      end
      default: ;
    endcase
  end

  always_ff @(posedge core_clk_in) begin
    if (srst_in) begin
      state_reg <= PPP_OFF;
      cnt_reg <= 16'h0000;
      ls_prev_reg <= 1'b0;
      wr_prev_reg <= 1'b1;
      pl_prev_reg <= 1'b0;
      cmd_reg <= CMD_NOP;
      addr_lo_reg <= 8'h00;
      addr_hi_reg <= 8'h00;
      dat_lo_reg <= 8'h00;
      dat_hi_reg <= 8'h00;
      fuse_lo_reg <= FUSE_LO_RESET;
      fuse_hi_reg <= FUSE_HI_RESET;
      fuse_ext_reg <= FUSE_EXT_RESET;
      lock_reg <= BYTE_ERASED;
      pend_lock_reg <= 1'b0;
      rb_reg <= 1'b0;
      prog_reg <= 1'b0;
      rd_reg <= 8'h00;
      oe_reg <= 1'b0;
      for (int i = 0; i < PAGE_WORDS; i++) begin
        flash_lo[i] <= BYTE_ERASED;
        flash_hi[i] <= BYTE_ERASED;
        ee[i] <= BYTE_ERASED;
        pbuf_lo[i] <= BYTE_ERASED;
        pbuf_hi[i] <= BYTE_ERASED;
      end
    end else begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      ls_prev_reg <= pins.load_strobe;
      wr_prev_reg <= pins.write_n;
      pl_prev_reg <= pins.page_buffer_latch;
      cmd_reg <= cmd_next;
      addr_lo_reg <= addr_lo_next;
      addr_hi_reg <= addr_hi_next;
      dat_lo_reg <= dat_lo_next;
      dat_hi_reg <= dat_hi_next;
      fuse_lo_reg <= fuse_lo_next;
      fuse_hi_reg <= fuse_hi_next;
      fuse_ext_reg <= fuse_ext_next;
      lock_reg <= lock_next;
      pend_lock_reg <= pend_lock_next;
      rb_reg <= rb_next;
      prog_reg <= prog_next;
      rd_reg <= rd_next;
      oe_reg <= oe_next;
      if (do_pload) begin
        pbuf_lo[widx] <= dat_lo_reg;
        pbuf_hi[widx] <= dat_hi_reg;
      end
      for (int i = 0; i < PAGE_WORDS; i++) begin
        // Programming only clears bits, so an unerased cell keeps its zeros.
        if (do_flash_wr) begin
          flash_lo[i] <= flash_lo[i] & pbuf_lo[i];
          flash_hi[i] <= flash_hi[i] & pbuf_hi[i];
        end
        if (do_ee_wr) ee[i] <= ee[i] & pbuf_lo[i];
        if (do_erase) begin
          flash_lo[i] <= BYTE_ERASED;
          flash_hi[i] <= BYTE_ERASED;
          if (fuse_hi_reg[PRESERVE_FUSE_BIT]) ee[i] <= BYTE_ERASED;
        end
        if (do_flash_wr || do_ee_wr || do_erase || (cmd_next == CMD_NOP && cmd_reg != CMD_NOP)) begin
          pbuf_lo[i] <= BYTE_ERASED;
          pbuf_hi[i] <= BYTE_ERASED;
        end
      end
    end
  end

  assign pins.ready_busy_out = rb_reg;
  assign pins.data_dev = rd_reg;
  assign pins.data_dev_oe = oe_reg;
  assign prog_mode_out = prog_reg;
  assign fuse_low_out = fuse_lo_reg;
  assign fuse_high_out = fuse_hi_reg;
  assign lock_out = lock_reg;
endmodule : ppp_device

// [src/ppp_host.sv]
// Programmer end: turns user requests into timed strobes on the pins.
module ppp_host (
  // Clock and reset
  input wire logic core_clk_in,
  input wire logic srst_in,
  // Programming pins
  ppp_if.host pins,
  // User request
  input wire logic req_valid_in,
  input wire logic [2:0] req_kind_in,
  input wire logic [1:0] req_act_in,
  input wire logic req_sel_hi_in,
  input wire logic req_sel_ext_in,
  input wire logic [7:0] req_data_in,
  output logic req_ready_out,
  output logic rsp_valid_out,
  output logic [7:0] rsp_data_out,
  output logic hv_enter_out
);
  import ppp_pkg::*;
  // Kinds: 0 enter, 1 load strobe, 2 page latch, 3 write, 4 read.
  typedef enum logic [2:0] {PH_OFF, PH_ENTRY, PH_IDLE, PH_SET, PH_PULSE, PH_WAITRB} ppp_hstate_e;
  ppp_hstate_e st_reg, st_next;
  logic [15:0] cnt_reg, cnt_next;
  logic [2:0] kind_reg, kind_next;
  logic [7:0] rsp_reg, rsp_next;
  logic rv_reg, rv_next, ls_reg, ls_next, pl_reg, pl_next, wr_reg, wr_next, oe_reg, oe_next;
  logic [1:0] act_reg, act_next;
  logic sel_hi_reg, sel_hi_next, sel_ext_reg, sel_ext_next, dq_oe_reg, dq_oe_next;
  logic [7:0] dq_reg, dq_next;
  logic go, pdone, pact;

  ppp_pulse_gen u_pulse (
    .core_clk_in(core_clk_in),
    .srst_in(srst_in),
    .start_in(go),
    .width_in(16'(PULSE_MIN_CYC)),
    .active_out(pact),
    .done_out(pdone)
  );

  always_comb begin
    st_next = st_reg;
    cnt_next = cnt_reg;
    kind_next = kind_reg;
    rsp_next = rsp_reg;
    rv_next = 1'b0;
    ls_next = ls_reg;
    pl_next = pl_reg;
    wr_next = wr_reg;
    oe_next = oe_reg;
    act_next = act_reg;
    sel_hi_next = sel_hi_reg;
    sel_ext_next = sel_ext_reg;
    dq_next = dq_reg;
    dq_oe_next = dq_oe_reg;
    go = 1'b0;
    unique case (st_reg)
      PH_OFF: if (req_valid_in && req_kind_in == 3'h0) begin
        act_next = ACT_ADDR;
        sel_hi_next = 1'b0;
        pl_next = 1'b0;
        st_next = PH_ENTRY;
        cnt_next = 16'h0000;
      end
      PH_ENTRY: begin
        // Pattern held, then the long wait before any command.
        if (cnt_reg == 16'(ENTRY_HOLD_CYC + CMD_WAIT_CYC)) st_next = PH_IDLE;
        else cnt_next = cnt_reg + 16'h0001;
      end
      PH_IDLE: if (req_valid_in) begin
        kind_next = req_kind_in;
        act_next = req_act_in;
        sel_hi_next = req_sel_hi_in;
        sel_ext_next = req_sel_ext_in;
        dq_next = req_data_in;
        dq_oe_next = req_kind_in != 3'h4;
        st_next = PH_SET;
      end
      PH_SET: begin
        go = 1'b1;
        st_next = PH_PULSE;
        unique case (kind_reg)
          3'h1: ls_next = 1'b1;
          3'h2: pl_next = 1'b1;
          3'h3: wr_next = 1'b0;
          3'h4: oe_next = 1'b0;
          default: ;
        endcase
      end
      PH_PULSE: if (pdone) begin
        if (!oe_reg) begin
          rsp_next = pins.data_bus;
          rv_next = 1'b1;
        end
        ls_next = 1'b0;
        pl_next = 1'b0;
        oe_next = 1'b1;
        wr_next = 1'b1;
        st_next = (kind_reg == 3'h3) ? PH_WAITRB : PH_IDLE;
        cnt_next = 16'h0002;
      end
      PH_WAITRB: begin
        // Device drops busy within a couple of cycles; no new request until ready.
        if (cnt_reg != 16'h0000) cnt_next = cnt_reg - 16'h0001;
        else if (pins.ready_busy_out) st_next = PH_IDLE;
      end
      default: st_next = PH_OFF;
    endcase
  end

  always_ff @(posedge core_clk_in) begin
    if (srst_in) begin
      st_reg <= PH_OFF;
      cnt_reg <= 16'h0000;
      kind_reg <= 3'h0;
      rsp_reg <= 8'h00;
      rv_reg <= 1'b0;
      ls_reg <= 1'b0;
      pl_reg <= 1'b0;
      wr_reg <= 1'b1;
      oe_reg <= 1'b1;
      act_reg <= ACT_IDLE;
      sel_hi_reg <= 1'b0;
      sel_ext_reg <= 1'b0;
      dq_reg <= 8'h00;
      dq_oe_reg <= 1'b0;
    end else begin
      st_reg <= st_next;
      cnt_reg <= cnt_next;
      kind_reg <= kind_next;
      rsp_reg <= rsp_next;
      rv_reg <= rv_next;
      ls_reg <= ls_next;
      pl_reg <= pl_next;
      wr_reg <= wr_next;
      oe_reg <= oe_next;
      act_reg <= act_next;
      sel_hi_reg <= sel_hi_next;
      sel_ext_reg <= sel_ext_next;
      dq_reg <= dq_next;
      dq_oe_reg <= dq_oe_next;
    end
  end

  assign pins.load_strobe = ls_reg;
  assign pins.page_buffer_latch = pl_reg;
  assign pins.write_n = wr_reg;
  assign pins.output_enable_n = oe_reg;
  assign {pins.action_select_bit1, pins.action_select_bit0} = act_reg;
  assign pins.byte_select_lo_hi = sel_hi_reg;
  assign pins.byte_select_extended = sel_ext_reg;
  assign pins.data_host = dq_reg;
  assign pins.data_host_oe = dq_oe_reg;
  assign req_ready_out = (st_reg == PH_IDLE) || (st_reg == PH_OFF);
  assign rsp_valid_out = rv_reg;
  assign rsp_data_out = rsp_reg;
  assign hv_enter_out = (st_reg != PH_OFF);
endmodule : ppp_host

// [verification/ppp_properties.sv]
// Concurrent checks on the pins between the programmer and device ends.
module ppp_properties (
  // Clock and reset
  input wire logic core_clk_in,
  input wire logic srst_in,
  // Programming pins
  input wire logic load_strobe,
  input wire logic write_n,
  input wire logic output_enable_n,
  input wire logic ready_busy_out,
  input wire logic data_host_oe,
  input wire logic data_dev_oe
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge core_clk_in);
  endclocking
  default disable iff (srst_in);
  sequence s_write_low;
    !write_n [*8];
  endsequence
  sequence s_busy_hold;
    !ready_busy_out [*8];
  endsequence
  a_load_width: assert property ($rose(load_strobe) |-> load_strobe [*8])
    else $error("Load strobe pulse too short.");
  a_write_width: assert property ($fell(write_n) |-> s_write_low)
    else $error("Write strobe pulse too short.");
  a_write_busy: assert property ($fell(write_n) && ready_busy_out |-> ##[1:4] !ready_busy_out)
    else $error("Write strobe did not start a busy period.");
  a_busy_hold: assert property ($fell(ready_busy_out) |-> s_busy_hold)
    else $error("Busy period ended too early.");
  a_busy_ends: assert property ($fell(ready_busy_out) |-> ##[1:200] ready_busy_out)
    else $error("Busy period never ended.");
  a_load_ready: assert property ($rose(load_strobe) |-> ready_busy_out)
    else $error("Load strobe given while busy.");
  a_dev_drive: assert property ($rose(data_dev_oe) |-> !output_enable_n && !$past(output_enable_n))
    else $error("Device drove data without output enable.");
  a_dev_answer: assert property ($fell(output_enable_n) |-> ##[1:3] data_dev_oe)
    else $error("Device did not drive data on output enable.");
  a_dev_release: assert property ($rose(output_enable_n) |-> ##[0:3] !data_dev_oe)
    else $error("Device kept driving data after output enable.");
  a_host_release: assert property (data_host_oe |-> output_enable_n)
    else $error("Programmer drove data during output enable.");
endmodule : ppp_properties

// [verification/parallel_programming_port_tb.sv]
// Self-checking bench joining the programmer and device ends of the programming port.
module parallel_programming_port_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import ppp_pkg::*;
  localparam int ERASE_N = 64;
  localparam int WRITE_N = 32;
  logic core_clk_in = 1'b0;
  logic srst_in = 1'b1;
  logic req_valid_in = 1'b0;
  logic [2:0] req_kind_in = 3'h0;
  logic [1:0] req_act_in = 2'h3;
  logic req_sel_hi_in = 1'b0;
  logic req_sel_ext_in = 1'b0;
  logic [7:0] req_data_in = 8'h00;
  logic req_ready_out, rsp_valid_out, hv_enter, prog_mode_out;
  logic [7:0] rsp_data_out, fuse_low_out, fuse_high_out, lock_out;
  int errors = 0;
  int tests_run = 0;

  always #12.5 core_clk_in = ~core_clk_in;
  ppp_if i_ppp_if ();
  ppp_host i_ppp_host (.core_clk_in(core_clk_in), .srst_in(srst_in), .pins(i_ppp_if.host),
    .req_valid_in(req_valid_in), .req_kind_in(req_kind_in), .req_act_in(req_act_in),
    .req_sel_hi_in(req_sel_hi_in), .req_sel_ext_in(req_sel_ext_in), .req_data_in(req_data_in),
    .req_ready_out(req_ready_out),
    .rsp_valid_out(rsp_valid_out), .rsp_data_out(rsp_data_out), .hv_enter_out(hv_enter));
  ppp_device #(.ERASE_CYC(ERASE_N), .WRITE_CYC(WRITE_N)) i_ppp_device (.core_clk_in(core_clk_in),
    .srst_in(srst_in), .pins(i_ppp_if.device), .hv_enter_in(hv_enter), .prog_mode_out(prog_mode_out),
    .fuse_low_out(fuse_low_out), .fuse_high_out(fuse_high_out), .lock_out(lock_out));
  ppp_properties i_ppp_properties (.core_clk_in(core_clk_in), .srst_in(srst_in),
    .load_strobe(i_ppp_if.load_strobe), .write_n(i_ppp_if.write_n), .output_enable_n(i_ppp_if.output_enable_n),
    .ready_busy_out(i_ppp_if.ready_busy_out), .data_host_oe(i_ppp_if.data_host_oe),
    .data_dev_oe(i_ppp_if.data_dev_oe));

  task automatic give_verdict();
    $display("Comparisons %0d, mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : give_verdict

  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  // Valid is held until ready is seen, so the request is taken at exactly one edge.
  task automatic send(input logic [2:0] kind, input logic [1:0] act, input logic hi, input logic ext,
                      input logic [7:0] data);
    int n;
    n = 0;
    @(posedge core_clk_in);
    req_valid_in <= 1'b1;
    req_kind_in <= kind;
    req_act_in <= act;
    req_sel_hi_in <= hi;
    req_sel_ext_in <= ext;
    req_data_in <= data;
    @(negedge core_clk_in);
    while (req_ready_out !== 1'b1 && n < 2000) begin
      @(negedge core_clk_in);
      n++;
    end
    @(posedge core_clk_in);
    req_valid_in <= 1'b0;
    check("request taken", 8'h01, {7'h00, n < 2000});
  endtask : send

  task automatic ld(input logic [1:0] act, input logic hi, input logic [7:0] data);
    send(3'h1, act, hi, 1'b0, data);
  endtask : ld

  task automatic cmd(input logic [7:0] code);
    ld(ACT_CMD, 1'b0, code);
  endtask : cmd

  task automatic latch();
    send(3'h2, ACT_IDLE, 1'b1, 1'b0, 8'h00);
  endtask : latch

  // The busy span equals the count, since the edge detect stages only delay its start; the margin is 4 cycles either way.
  task automatic wr(input logic hi, input logic ext, input int cyc);
    int n;
    int low;
    n = 0;
    low = 0;
    send(3'h3, ACT_IDLE, hi, ext, 8'h00);
    while (i_ppp_if.ready_busy_out !== 1'b0 && n < 40) begin
      @(negedge core_clk_in);
      n++;
    end
    while (i_ppp_if.ready_busy_out === 1'b0 && low < 400) begin
      @(negedge core_clk_in);
      low++;
    end
    check("busy span", 8'h01, {7'h00, low >= cyc - 4 && low <= cyc + 4});
  endtask : wr

  task automatic rd(input logic hi, input logic ext, input logic [7:0] exp, input string what);
    int n;
    n = 0;
    send(3'h4, ACT_IDLE, hi, ext, 8'h00);
    while (rsp_valid_out !== 1'b1 && n < 60) begin
      @(negedge core_clk_in);
      n++;
    end
    check("read answered", 8'h01, {7'h00, n < 60});
    check(what, exp, rsp_data_out);
  endtask : rd

  task automatic t_entry();
    int n;
    n = 0;
    check("bus idle level", 8'hFF, i_ppp_if.data_bus);
    check("busy before entry", 8'h00, {7'h00, i_ppp_if.ready_busy_out});
    send(3'h0, ACT_ADDR, 1'b0, 1'b0, 8'h00);
    while (prog_mode_out !== 1'b1 && n < 2000) begin
      @(negedge core_clk_in);
      n++;
    end
    check("prog mode", 8'h01, {7'h00, prog_mode_out});
    repeat (CMD_WAIT_CYC) @(posedge core_clk_in);
    check("ready after entry", 8'h01, {7'h00, i_ppp_if.ready_busy_out});
  endtask : t_entry

  task automatic t_sig();
    logic [7:0] sig[3];
    sig = '{SIG_BYTE0, SIG_BYTE1, SIG_BYTE2};
    cmd(CMD_RD_SIG);
    for (int i = 0; i < 3; i++) begin
      ld(ACT_ADDR, 1'b0, 8'(i));
      rd(1'b0, 1'b0, sig[i], "signature byte");
    end
    ld(ACT_ADDR, 1'b0, 8'h00);
    rd(1'b1, 1'b0, CAL_BYTE, "calibration byte");
    cmd(CMD_RD_FUSE_LOCK);
    rd(1'b0, 1'b0, FUSE_LO_RESET, "fuse low");
    rd(1'b1, 1'b1, FUSE_HI_RESET, "fuse high");
    rd(1'b0, 1'b1, FUSE_EXT_RESET, "fuse extended");
    rd(1'b1, 1'b0, 8'hFF, "lock bits");
  endtask : t_sig

  task automatic t_mem();
    cmd(CMD_WR_FLASH);
    ld(ACT_ADDR, 1'b0, 8'h03);
    ld(ACT_DATA, 1'b0, 8'h34);
    ld(ACT_DATA, 1'b1, 8'h12);
    latch();
    ld(ACT_ADDR, 1'b1, 8'h00);
    wr(1'b0, 1'b0, WRITE_N);
    cmd(CMD_NOP);
    cmd(CMD_RD_FLASH);
    ld(ACT_ADDR, 1'b0, 8'h03);
    rd(1'b0, 1'b0, 8'h34, "flash low byte");
    rd(1'b1, 1'b0, 8'h12, "flash high byte");
    ld(ACT_ADDR, 1'b0, 8'h04);
    ld(ACT_IDLE, 1'b0, 8'h03);
    rd(1'b0, 1'b0, BYTE_ERASED, "unwritten word");
    cmd(CMD_WR_EEPROM);
    ld(ACT_ADDR, 1'b0, 8'h05);
    ld(ACT_DATA, 1'b0, 8'h5C);
    latch();
    wr(1'b0, 1'b0, WRITE_N);
    cmd(CMD_RD_EEPROM);
    ld(ACT_ADDR, 1'b0, 8'h05);
    rd(1'b0, 1'b0, 8'h5C, "eeprom byte");
  endtask : t_mem

  task automatic t_fuse();
    cmd(CMD_WR_FUSE);
    ld(ACT_DATA, 1'b0, 8'hA5);
    wr(1'b0, 1'b0, WRITE_N);
    check("fuse low", 8'hA5, fuse_low_out);
    ld(ACT_DATA, 1'b0, 8'hD7);
    wr(1'b1, 1'b0, WRITE_N);
    check("fuse high", 8'hD7, fuse_high_out);
    cmd(CMD_WR_LOCK);
    ld(ACT_DATA, 1'b0, 8'hFC);
    wr(1'b0, 1'b0, WRITE_N);
    check("lock bits", 8'hFC, lock_out);
  endtask : t_fuse

  task automatic erase_check(input logic [7:0] ee_exp);
    cmd(CMD_CHIP_ERASE);
    wr(1'b0, 1'b0, ERASE_N);
    check("lock after erase", 8'hFF, lock_out);
    check("fuse kept", 8'hA5, fuse_low_out);
    cmd(CMD_RD_FLASH);
    ld(ACT_ADDR, 1'b0, 8'h03);
    rd(1'b0, 1'b0, BYTE_ERASED, "flash erased");
    cmd(CMD_RD_EEPROM);
    ld(ACT_ADDR, 1'b0, 8'h05);
    rd(1'b0, 1'b0, ee_exp, "eeprom after erase");
  endtask : erase_check

  task automatic t_erase();
    erase_check(8'h5C);
    // Word 3 held 0x34 before the erase, so 0x0F only reads back if the erase really ran.
    cmd(CMD_WR_FLASH);
    ld(ACT_ADDR, 1'b0, 8'h03);
    ld(ACT_DATA, 1'b0, 8'h0F);
    latch();
    cmd(CMD_NOP);
    cmd(CMD_WR_FLASH);
    wr(1'b0, 1'b0, WRITE_N);
    cmd(CMD_RD_FLASH);
    rd(1'b0, 1'b0, BYTE_ERASED, "page dropped by nop");
    cmd(CMD_WR_FLASH);
    latch();
    wr(1'b0, 1'b0, WRITE_N);
    cmd(CMD_RD_FLASH);
    rd(1'b0, 1'b0, 8'h0F, "flash rewritten after erase");
    cmd(CMD_WR_FUSE);
    ld(ACT_DATA, 1'b0, FUSE_HI_RESET);
    wr(1'b1, 1'b0, WRITE_N);
    erase_check(BYTE_ERASED);
  endtask : t_erase

  initial begin
    repeat (4) @(posedge core_clk_in);
    srst_in <= 1'b0;
    t_entry();
    t_sig();
    t_mem();
    t_fuse();
    t_erase();
    give_verdict();
  end

  initial begin
    #(40000 * 25);
    errors++;
    $display("Watchdog expired before the tests ended.");
    give_verdict();
  end
endmodule : parallel_programming_port_tb
